// *** core/ipvu_consts.svh ***
/*
  Constants of the interrupt priority and vector unit: sizes, register
  word addresses, field positions and reset values.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef IPVU_CONSTS_SVH
`define IPVU_CONSTS_SVH

// Sizes
`define NUM_SRC 118
`define DATA_W 16
`define ADDR_W 6
`define FLAG_WORDS 8
`define FLAG_BITS 128
`define PRIO_WORDS 30
`define PRIO_SLOTS 120
`define SRC_PER_PRIO 4
`define PRIO_STRIDE 4
`define PRIO_W 3
`define N_EV 2
`define SRC_MASK 128'h003F_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF

// Register word addresses
`define A_FLAG_BASE 6'h00
`define A_EN_BASE 6'h08
`define A_PRIO_BASE 6'h10
`define A_PEND 6'h2E
`define A_STATUS 6'h2F
`define A_CORE 6'h30
`define A_IRQ_STAT 6'h31
`define A_IRQ_MASK 6'h32

// Field positions
`define PEND_VEC_LSB 0
`define PEND_LVL_LSB 8
`define SR_BITS_LSB 5
`define CORE_TOP_LSB 3
`define EV_NEW 0
`define EV_LOST 1

// Values
`define VEC_OFFSET 7'h08
`define PRIO_RST 3'h0
`define CPU_BITS_RST 3'h0

`endif

// *** core/ipvu_pkg.sv ***
/*
  Types of the interrupt priority and vector unit.
  Assumes ipvu_consts.svh is on the include path.
*/
`include "ipvu_consts.svh"

package ipvu_pkg;

  typedef logic [`DATA_W-1:0] word_t;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`PRIO_W-1:0] prio_t;

  // Whole state of the unit, registered in one place
  typedef struct packed {
    logic [2:0] pin_sync;
    logic pin_level;
    logic [`FLAG_BITS-1:0] flags;
    logic [`FLAG_BITS-1:0] enables;
    logic [`PRIO_SLOTS-1:0][`PRIO_W-1:0] prio;
    prio_t cpu_bits;
    logic [6:0] vec;
    logic [3:0] lvl;
    logic valid;
    logic [`N_EV-1:0] irq_stat;
    logic [`N_EV-1:0] irq_mask;
    word_t rdata;
  } unit_state_t;

endpackage

// *** core/interrupt_priority_vector_unit.sv ***
/*
  Interrupt priority and vector unit: per-source request flags, enables
  and priority fields, selection of the winning request, the pending
  vector register, the CPU priority level and a summary interrupt.
  Assumes one clock; peripheral events are one-cycle pulses on that
  clock; the external pin is asynchronous; the trap logic of the core
  drives the top priority bit.
*/
// How it works
// - Each source has a three-bit priority field, giving eight levels.
// - The chosen request's vector goes into a 7-bit field and its level into a 4-bit field of the pending vector register.
// - The latched level is the priority assigned to the request being presented.
// - Flags, enables and priorities are laid out in natural source order.
// - Source 0 (vector 8) uses flag and enable bit 0 and priority bits 2 to 0 of the first words.
// - The status register holds the low three CPU priority bits at bits 7 to 5.
// - Software writes to those bits change the CPU priority level.
// - A top bit from the core control register completes the four-bit CPU level.
// - The top bit is read-only to software, so traps cannot be masked.
// - A flag is set by its source and stays set until software clears it.
// - Each source has its own enable bit that blocks or passes its request.
`include "ipvu_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module interrupt_priority_vector_unit
  import ipvu_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire ipvu_pkg::addr_t i_addr,
  input wire ipvu_pkg::word_t i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output ipvu_pkg::word_t o_rdata,
  input wire logic [`NUM_SRC-1:0] i_source_event,
  input wire logic i_external_irq_zero,
  input wire logic i_priority_top_bit,
  output logic [6:0] o_vector_number,
  output logic [3:0] o_pending_level,
  output logic o_request_valid,
  output logic [3:0] o_cpu_priority_level,
  output logic o_irq
);

  import ipvu_pkg::*;

  unit_state_t st;
  unit_state_t next_st;
  logic [`FLAG_BITS-1:0] req;
  logic [`FLAG_BITS-1:0] set_vec;
  logic pin_agree;
  logic pin_rise;
  logic [6:0] best_idx;
  prio_t best_prio;
  logic found;
  logic present;
  logic [`N_EV-1:0] ev;
  logic [2:0] fidx;
  logic [4:0] pidx;

  // Word hit test, shared by the read and write decoders
  function automatic logic in_group(input addr_t a, input addr_t base,
                                    input addr_t count);
    in_group = (a >= base) && (a < addr_t'(base + count));
  endfunction

  // Enabled pending requests, one per source
  genvar gi;
  generate
    for (gi = 0; gi < `FLAG_BITS; gi++)
    begin : g_req
      if (gi < `NUM_SRC)
      begin : g_src
        assign req[gi] = st.flags[gi] & st.enables[gi];
      end
      else
      begin : g_pad
        assign req[gi] = 1'b0;
      end
    end
  endgenerate

  // Pin filter: a change counts once the second and third stages agree
  assign pin_agree = st.pin_sync[1] == st.pin_sync[2];
  assign pin_rise = pin_agree && st.pin_sync[2] && !st.pin_level;

  // Source 0 is also set by a filtered rising edge of the external pin
  always_comb
  begin
    set_vec = {{(`FLAG_BITS - `NUM_SRC){1'b0}}, i_source_event};
    set_vec[0] = i_source_event[0] | pin_rise;
  end

  assign fidx = 3'(i_addr - `A_FLAG_BASE);
  assign pidx = 5'(i_addr - `A_PRIO_BASE);

  // Highest priority wins; strict compare keeps the lower number on ties
  always_comb
  begin
    best_idx = 7'h00;
    best_prio = 3'h0;
    found = 1'b0;
    for (int i = 0; i < `NUM_SRC; i++)
    begin
      if (req[i] && (st.prio[i] > best_prio))
      begin
        best_idx = 7'(i);
        best_prio = st.prio[i];
        found = 1'b1;
      end
    end
    // Four-bit CPU level; a set top bit blocks every user source
    present = found &&
              ({1'b0, best_prio} > {i_priority_top_bit, st.cpu_bits});
  end

  // Next state of the whole unit
  always_comb
  begin
    next_st = st;
    next_st.rdata = 16'h0000;

    // Pin synchroniser; stage 0 only feeds stage 1
    next_st.pin_sync = {st.pin_sync[1:0], i_external_irq_zero};
    if (pin_agree)
    begin
      next_st.pin_level = st.pin_sync[2];
    end

    // Register writes
    if (i_write)
    begin
      if (in_group(i_addr, `A_FLAG_BASE, addr_t'(`FLAG_WORDS)))
      begin
        next_st.flags[{fidx, 4'h0} +: `DATA_W] = i_wdata;
      end
      if (in_group(i_addr, `A_EN_BASE, addr_t'(`FLAG_WORDS)))
      begin
        next_st.enables[{3'(i_addr - `A_EN_BASE), 4'h0} +: `DATA_W] =
          i_wdata;
      end
      if (in_group(i_addr, `A_PRIO_BASE, addr_t'(`PRIO_WORDS)))
      begin
        for (int k = 0; k < `SRC_PER_PRIO; k++)
        begin
          next_st.prio[7'({pidx, 2'b00}) + 7'(k)] =
            i_wdata[k * `PRIO_STRIDE +: `PRIO_W];
        end
      end
      if (i_addr == `A_STATUS)
      begin
        next_st.cpu_bits = i_wdata[`SR_BITS_LSB +: `PRIO_W];
      end
      if (i_addr == `A_IRQ_STAT)
      begin
        next_st.irq_stat = st.irq_stat & ~i_wdata[`N_EV-1:0];
      end
      if (i_addr == `A_IRQ_MASK)
      begin
        next_st.irq_mask = i_wdata[`N_EV-1:0];
      end
      // Core control word takes no write: the top bit is trap-owned
    end

    // Source events win over a clear in the same cycle
    next_st.flags = (next_st.flags | set_vec) & `SRC_MASK;
    next_st.enables = next_st.enables & `SRC_MASK;
    for (int s = `NUM_SRC; s < `PRIO_SLOTS; s++)
    begin
      next_st.prio[s] = 3'h0;
    end

    // Pending vector register follows the current winner
    next_st.valid = present;
    next_st.vec = present ? 7'(best_idx + `VEC_OFFSET) : 7'h00;
    next_st.lvl = present ? {1'b0, best_prio} : 4'h0;

    // Events: a new vector presented, and a source firing while pending
    ev[`EV_NEW] = present && (!st.valid || (next_st.vec != st.vec));
    ev[`EV_LOST] = |(set_vec & st.flags);
    next_st.irq_stat = next_st.irq_stat | ev;

    // Read data stand in the cycle after the strobe only
    if (i_read)
    begin
      if (in_group(i_addr, `A_FLAG_BASE, addr_t'(`FLAG_WORDS)))
      begin
        next_st.rdata = st.flags[{fidx, 4'h0} +: `DATA_W];
      end
      else if (in_group(i_addr, `A_EN_BASE, addr_t'(`FLAG_WORDS)))
      begin
        next_st.rdata = st.enables[{3'(i_addr - `A_EN_BASE), 4'h0} +: `DATA_W];
      end
      else if (in_group(i_addr, `A_PRIO_BASE, addr_t'(`PRIO_WORDS)))
      begin
        for (int k = 0; k < `SRC_PER_PRIO; k++)
        begin
          next_st.rdata[k * `PRIO_STRIDE +: `PRIO_W] =
            st.prio[7'({pidx, 2'b00}) + 7'(k)];
        end
      end
      else if (i_addr == `A_PEND)
      begin
        next_st.rdata[`PEND_VEC_LSB +: 7] = st.vec;
        next_st.rdata[`PEND_LVL_LSB +: 4] = st.lvl;
      end
      else if (i_addr == `A_STATUS)
      begin
        next_st.rdata[`SR_BITS_LSB +: `PRIO_W] = st.cpu_bits;
      end
      else if (i_addr == `A_CORE)
      begin
        next_st.rdata[`CORE_TOP_LSB] = i_priority_top_bit;
      end
      else if (i_addr == `A_IRQ_STAT)
      begin
        next_st.rdata[`N_EV-1:0] = st.irq_stat;
      end
      else if (i_addr == `A_IRQ_MASK)
      begin
        next_st.rdata[`N_EV-1:0] = st.irq_mask;
      end
    end
  end

  // State register; priorities reset to a fixed level
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      st <= '0;
      st.prio <= {`PRIO_SLOTS{`PRIO_RST}};
      st.cpu_bits <= `CPU_BITS_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from state, except the CPU level's top bit, taken from i_priority_top_bit
  assign o_rdata = st.rdata;
  assign o_vector_number = st.vec;
  assign o_pending_level = st.lvl;
  assign o_request_valid = st.valid;
  assign o_cpu_priority_level = {i_priority_top_bit, st.cpu_bits};
  assign o_irq = |(st.irq_stat & st.irq_mask);

endmodule

`default_nettype wire

// *** test/ipvu_sva.sv ***
/*
  Checker of the interrupt priority and vector unit.
  Assumes binding to the unit's top module; sees its ports only.
*/
`include "ipvu_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ipvu_sva (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire ipvu_pkg::addr_t i_addr,
  input wire logic i_read,
  input wire logic i_priority_top_bit,
  input wire ipvu_pkg::word_t o_rdata,
  input wire logic [6:0] o_vector_number,
  input wire logic [3:0] o_pending_level,
  input wire logic o_request_valid,
  input wire logic [3:0] o_cpu_priority_level
);
  import ipvu_pkg::*;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Read strobe at one register; data follows one cycle later
  sequence s_rd(ad);
    i_read && i_addr == ad;
  endsequence
  property p_vec;
    o_request_valid |-> o_vector_number inside {[8:125]};
  endproperty
  a_vec: assert property (p_vec) else $error("vector out of range");
  property p_idle;
    !o_request_valid |-> o_vector_number == 0 && o_pending_level == 0;
  endproperty
  a_idle: assert property (p_idle) else $error("idle fields set");
  property p_lvl;
    o_request_valid |-> o_pending_level inside {[1:7]};
  endproperty
  a_lvl: assert property (p_lvl) else $error("level not 3-bit");
  property p_top;
    o_cpu_priority_level[3] == i_priority_top_bit;
  endproperty
  a_top: assert property (p_top) else $error("top bit lost");
  // Uses last cycle's level: selection runs one cycle behind state
  property p_above;
    o_request_valid |-> o_pending_level > $past(o_cpu_priority_level);
  endproperty
  a_above: assert property (p_above) else $error("not above cpu");
  property p_pend;
    s_rd(`A_PEND) |=> o_rdata == {4'h0, $past(o_pending_level), 1'b0,
      $past(o_vector_number)};
  endproperty
  a_pend: assert property (p_pend) else $error("pending read");
  property p_stat;
    s_rd(`A_STATUS) |=>
      {1'b0, o_rdata[7:5]} == ($past(o_cpu_priority_level) & 4'h7);
  endproperty
  a_stat: assert property (p_stat) else $error("status read");
  property p_core;
    s_rd(`A_CORE) |=> o_rdata[3] == $past(i_priority_top_bit);
  endproperty
  a_core: assert property (p_core) else $error("core read");
endmodule
bind interrupt_priority_vector_unit ipvu_sva i_ipvu_sva (
  .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_read(i_read),
  .i_priority_top_bit(i_priority_top_bit), .o_rdata(o_rdata),
  .o_vector_number(o_vector_number), .o_pending_level(o_pending_level),
  .o_request_valid(o_request_valid),
  .o_cpu_priority_level(o_cpu_priority_level));
`default_nettype wire

// *** test/cpu_core_model.sv ***
/*
  Core model: trap logic owning the top priority bit, vector taker.
  Assumes the unit's clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_trap,
  input wire logic i_request_valid,
  input wire logic [6:0] i_vector_number,
  output logic o_priority_top_bit,
  output logic [6:0] o_last_vector
);
  // Only traps move the top bit, so software cannot mask them
  always_ff @(posedge i_clock or posedge i_rst)
    if (i_rst)
    begin
      o_priority_top_bit <= 1'b0;
      o_last_vector <= 7'h00;
    end
    else
    begin
      o_priority_top_bit <= i_trap;
      if (i_request_valid) o_last_vector <= i_vector_number;
    end
endmodule
`default_nettype wire

// *** test/test_interrupt_priority_vector_unit.sv ***
/*
  Testbench of the interrupt priority and vector unit.
  Assumes the unit, its checker and the core model compile first.
*/
`include "ipvu_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_priority_vector_unit;
  import ipvu_pkg::*;
  logic i_clock, i_rst, i_write, i_read, pin, trap, valid, top, irq;
  addr_t i_addr;
  word_t i_wdata, o_rdata;
  logic [`NUM_SRC-1:0] ev;
  logic [6:0] vec, last;
  logic [3:0] lvl, cpu;
  logic [2:0] pa, pb;
  logic [31:0] seed;
  int mismatches, cmp_count, a, b, w;
  interrupt_priority_vector_unit i_interrupt_priority_vector_unit (
    .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
    .i_source_event(ev), .i_external_irq_zero(pin),
    .i_priority_top_bit(top), .o_vector_number(vec),
    .o_pending_level(lvl), .o_request_valid(valid),
    .o_cpu_priority_level(cpu), .o_irq(irq));
  cpu_core_model i_cpu_core_model (.i_clock(i_clock), .i_rst(i_rst),
    .i_trap(trap), .i_request_valid(valid), .i_vector_number(vec),
    .o_priority_top_bit(top), .o_last_vector(last));
  initial
  begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected winner: higher level wins, the lower order keeps a tie
  function automatic int pick(input int x, input int y,
                              input logic [2:0] px, input logic [2:0] py);
    return (py > px) ? y : x;
  endfunction
  task automatic chk(input word_t g, input word_t e);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input addr_t ad, input word_t d);
    @(posedge i_clock);
    i_write <= 1'b1;
    i_addr <= ad;
    i_wdata <= d;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  task automatic rd(input addr_t ad, input word_t e);
    @(posedge i_clock);
    i_read <= 1'b1;
    i_addr <= ad;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  // Pulse two sources together, then let selection settle
  task automatic fire(input int x, input int y);
    @(posedge i_clock);
    ev[x] <= 1'b1;
    // One assignment per bit and time step, also when both are one source
    if (y != x) ev[y] <= 1'b1;
    @(posedge i_clock);
    ev <= '0;
    repeat (2) @(posedge i_clock);
    #1;
  endtask
  task automatic req(input logic [3:0] l, input logic [6:0] v);
    chk({valid, 3'h0, lvl, 1'b0, vec}, {l != 0, 3'h0, l, 1'b0, v});
  endtask
  // Writes a whole priority word, so neighbours go to zero
  task automatic setp(input int n, input logic [2:0] p);
    wr(addr_t'(`A_PRIO_BASE + n / 4), word_t'(p) << (4 * (n % 4)));
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog: a hang counts as a failure
  initial
  begin
    repeat (20000) @(posedge i_clock);
    mismatches++;
    end_of_test;
  end
  initial
  begin
    {i_rst, i_write, i_read, pin, trap} = 5'h10;
    {i_addr, i_wdata, ev} = '0;
    {mismatches, cmp_count} = '0;
    seed = 32'h64376ED0;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    setp(0, 3'h5);
    wr(`A_EN_BASE, 16'h0001);
    wr(`A_IRQ_MASK, 16'h0001);
    fire(0, 0);
    req(4'h5, 7'h08);
    rd(`A_PEND, 16'h0508);
    repeat (4) @(posedge i_clock);
    #1 req(4'h5, 7'h08);
    chk({15'h0, irq}, 16'h0001);
    wr(`A_IRQ_STAT, 16'h0001);
    #1 chk({15'h0, irq}, 16'h0000);
    // Level 5 hides a level-5 request, level 4 shows it again
    wr(`A_STATUS, 16'h00A0);
    repeat (2) @(posedge i_clock);
    #1 req(4'h0, 7'h00);
    chk({12'h000, cpu}, 16'h0005);
    rd(`A_STATUS, 16'h00A0);
    wr(`A_STATUS, 16'h0080);
    repeat (2) @(posedge i_clock);
    #1 req(4'h5, 7'h08);
    @(posedge i_clock);
    trap <= 1'b1;
    wr(`A_CORE, 16'h0000);
    repeat (2) @(posedge i_clock);
    #1 chk({12'h000, cpu}, 16'h000C);
    rd(`A_CORE, 16'h0008);
    trap <= 1'b0;
    wr(`A_STATUS, 16'h0000);
    wr(`A_EN_BASE, 16'h0000);
    repeat (2) @(posedge i_clock);
    #1 req(4'h0, 7'h00);
    wr(`A_FLAG_BASE, 16'h0000);
    // Every source enabled; random pairs, first three are ties
    for (int k = 0; k < 8; k++) wr(addr_t'(`A_EN_BASE + k), 16'hFFFF);
    for (int k = 0; k < 12; k++)
    begin
      seed = lfsr(seed);
      a = seed[15:0] % 100;
      b = a + 4 + seed[27:16] % 14;
      seed = lfsr(seed);
      pa = 3'(seed[7:0] % 7 + 1);
      pb = (k < 3) ? pa : seed[10:8];
      setp(a, pa);
      setp(b, pb);
      fire(a, b);
      w = pick(a, b, pa, pb);
      req((w == b) ? pb : pa, 7'(w + 8));
      wr(addr_t'(`A_FLAG_BASE + a / 16), 16'h0000);
      wr(addr_t'(`A_FLAG_BASE + b / 16), 16'h0000);
    end
    // Pin edge passes a filter before setting the first flag
    setp(0, 3'h5);
    pin <= 1'b1;
    for (int i = 0; i < 12 && valid !== 1'b1; i++) @(posedge i_clock);
    // A filter that never fires is a failure, not a hang
    if (valid !== 1'b1)
    begin
      chk({15'h0000, valid}, 16'h0001);
      end_of_test;
    end
    #1 req(4'h5, 7'h08);
    chk({9'h000, last}, 16'h0008);
    pin <= 1'b0;
    rd(6'h3F, 16'h0000);
    end_of_test;
  end
endmodule
`default_nettype wire
